/* File: hdl/cgu_pkg.sv */
package cgu_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------
	localparam logic [11:0] CGU_OFF_CTRL_ONE = 12'h000;
	localparam logic [11:0] CGU_OFF_CTRL_TWO = 12'h004;
	localparam logic [11:0] CGU_OFF_COARSE = 12'h008;
	localparam logic [11:0] CGU_OFF_STATUS = 12'h00C;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CGU_POS_SRC = 6;
	localparam int CGU_POS_REFERENCE_DIVIDER_SELECT = 3;
	localparam int CGU_POS_IREF_SEL = 2;
	localparam int CGU_POS_IREF_EN = 1;
	localparam int CGU_POS_IREF_STOP = 0;
	localparam int CGU_POS_BUS_DIVIDER_SELECT = 6;
	localparam int CGU_POS_RANGE = 5;
	localparam int CGU_POS_HGAIN = 4;
	localparam int CGU_POS_LOWPWR = 3;
	localparam int CGU_POS_EREF_SEL = 2;
	localparam int CGU_POS_EREF_EN = 1;
	localparam int CGU_POS_EREF_STOP = 0;
	localparam int CGU_POS_IREF_STAT = 4;
	localparam int CGU_POS_MODE_STAT = 2;
	localparam int CGU_POS_OSC_RDY = 1;
	localparam int CGU_POS_FINE = 0;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [1:0] CGU_RST_SRC = 2'h0;
	localparam logic [2:0] CGU_RST_REFERENCE_DIVIDER_SELECT = 3'h0;
	localparam logic CGU_RST_IREF_SEL = 1'b1;
	localparam logic [1:0] CGU_RST_BUS_DIVIDER_SELECT = 2'h1;
	localparam logic [7:0] CGU_RST_COARSE = 8'h80;
	localparam logic CGU_RST_FINE = 1'b0;

	// ------------------------------------------------------------
	// Source select codes
	// ------------------------------------------------------------
	localparam logic [1:0] CGU_SRC_FLL = 2'h0;
	localparam logic [1:0] CGU_SRC_IREF = 2'h1;
	localparam logic [1:0] CGU_SRC_EREF = 2'h2;

	// Operating modes, Gray coded along the usual path
	typedef enum logic [2:0] {
		CGU_ENGAGED_INTERNAL_MODE = 3'h0,
		CGU_ENGAGED_EXTERNAL_MODE = 3'h1,
		CGU_BYPASSED_EXTERNAL_MODE = 3'h3,
		CGU_BYPASSED_INTERNAL_MODE = 3'h2,
		CGU_BYPASSED_INTERNAL_LOW_POWER_MODE = 3'h6,
		CGU_BYPASSED_EXTERNAL_LOW_POWER_MODE = 3'h7,
		CGU_STOP_MODE = 3'h5
	} cgu_mode_t;

	// Control lines to the external low-power oscillator
	typedef struct packed {
		logic high_gain_select;
		logic range_select;
		logic external_reference_select;
		logic external_reference_enable;
		logic external_reference_stop_enable;
	} cgu_osc_ctrl_t;

endpackage

/* File: hdl/cgu_top.sv */
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
// Operation
// - presetn reset enters engaged internal mode; por_n alone keeps mode
// - Bus divider resets to divide by two
// - Bus clock is half unit clock output
// - Power-on loads adjust 0x80/0; others keep
// - Three system sources; FLL internal/external reference
// - Bus divider ratios 1, 2, 4, 8
// - Reference divider chosen by 3-bit select
// - Nine-bit adjust is coarse byte plus fine
// - Debug clock is DCO divided by two
// - Five oscillator control outputs driven
// - Engaged internal: FLL, internal reference, debug
// - Engaged external: FLL, external reference, debug
// - Bypassed internal: FLL on, internal source
// - Bypassed internal low power: FLL off
// - Bypassed external: FLL on, external source
// - Bypassed external low power: FLL off
// - Stop: no clocks, references per stop-enable
// - Source codes FLL/internal/external; 11 as 00
// - Reference divided by two to its code
// - Bus divider codes 1,2,4,8; reset 01
module cgu_top (
	// ------------------------------------------------------------
	// Clock and resets
	// ------------------------------------------------------------
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Clock ticks, one pclk pulse per rising edge of each source
	input wire logic dco_tick,
	input wire logic internal_reference_tick,
	input wire logic external_reference_tick,
	// System state
	input wire logic stop_request,
	input wire logic debug_active,
	input wire logic oscillator_ready_in,
	// Oscillator and FLL controls
	output cgu_pkg::cgu_osc_ctrl_t osc_ctrl,
	output logic fll_enable,
	output logic fll_reference_tick,
	output logic [8:0] internal_reference_trim,
	output logic internal_reference_active,
	// Clock outputs
	output logic unit_clock_tick,
	output logic bus_clock,
	output logic debug_clock,
	output cgu_pkg::cgu_mode_t mode
);

	// ------------------------------------------------------------
	// Register fields
	// ------------------------------------------------------------
	logic [1:0] source_select, next_source_select;
	logic [2:0] reference_divider_select, next_reference_divider_select;
	logic internal_reference_select, next_internal_reference_select;
	logic internal_reference_enable, next_internal_reference_enable;
	logic internal_reference_stop_enable, next_internal_reference_stop_enable;
	logic [1:0] bus_divider_select, next_bus_divider_select;
	logic range_select, next_range_select;
	logic high_gain_select, next_high_gain_select;
	logic low_power_select, next_low_power_select;
	logic external_reference_select, next_external_reference_select;
	logic external_reference_enable, next_external_reference_enable;
	logic external_reference_stop_enable, next_external_reference_stop_enable;
	logic [7:0] coarse_adjust, next_coarse_adjust;
	logic fine_adjust, next_fine_adjust;
	logic [31:0] next_prdata;

	logic wr_en;
	logic rd_setup;
	logic addr_hit;
	logic [7:0] wbyte;

	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite & pstrb[0];
	assign rd_setup = psel & ~penable & ~pwrite;
	assign wbyte = pwdata[7:0];
	assign addr_hit = (paddr == cgu_pkg::CGU_OFF_CTRL_ONE) |
		(paddr == cgu_pkg::CGU_OFF_CTRL_TWO) |
		(paddr == cgu_pkg::CGU_OFF_COARSE) |
		(paddr == cgu_pkg::CGU_OFF_STATUS);
	// Unmapped addresses answer with an error in the access phase
	assign pslverr = psel & penable & ~addr_hit;

	// ------------------------------------------------------------
	// Status state
	// ------------------------------------------------------------
	logic [1:0] clock_mode_status, next_clock_mode_status;
	logic internal_reference_status, next_internal_reference_status;
	logic oscillator_ready, next_oscillator_ready;

	// ------------------------------------------------------------
	// Control register writes
	// ------------------------------------------------------------
	always_comb begin
		next_source_select = source_select;
		next_reference_divider_select = reference_divider_select;
		next_internal_reference_select = internal_reference_select;
		next_internal_reference_enable = internal_reference_enable;
		next_internal_reference_stop_enable = internal_reference_stop_enable;
		next_bus_divider_select = bus_divider_select;
		next_range_select = range_select;
		next_high_gain_select = high_gain_select;
		next_low_power_select = low_power_select;
		next_external_reference_select = external_reference_select;
		next_external_reference_enable = external_reference_enable;
		next_external_reference_stop_enable = external_reference_stop_enable;
		if (wr_en && paddr == cgu_pkg::CGU_OFF_CTRL_ONE) begin
			next_source_select = wbyte[cgu_pkg::CGU_POS_SRC +: 2];
			next_reference_divider_select = wbyte[cgu_pkg::CGU_POS_REFERENCE_DIVIDER_SELECT +: 3];
			next_internal_reference_select = wbyte[cgu_pkg::CGU_POS_IREF_SEL];
			next_internal_reference_enable = wbyte[cgu_pkg::CGU_POS_IREF_EN];
			next_internal_reference_stop_enable = wbyte[cgu_pkg::CGU_POS_IREF_STOP];
		end
		if (wr_en && paddr == cgu_pkg::CGU_OFF_CTRL_TWO) begin
			next_bus_divider_select = wbyte[cgu_pkg::CGU_POS_BUS_DIVIDER_SELECT +: 2];
			next_range_select = wbyte[cgu_pkg::CGU_POS_RANGE];
			next_high_gain_select = wbyte[cgu_pkg::CGU_POS_HGAIN];
			next_low_power_select = wbyte[cgu_pkg::CGU_POS_LOWPWR];
			next_external_reference_select = wbyte[cgu_pkg::CGU_POS_EREF_SEL];
			next_external_reference_enable = wbyte[cgu_pkg::CGU_POS_EREF_EN];
			next_external_reference_stop_enable = wbyte[cgu_pkg::CGU_POS_EREF_STOP];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			source_select <= cgu_pkg::CGU_RST_SRC;
			reference_divider_select <= cgu_pkg::CGU_RST_REFERENCE_DIVIDER_SELECT;
			internal_reference_select <= cgu_pkg::CGU_RST_IREF_SEL;
			internal_reference_enable <= 1'b0;
			internal_reference_stop_enable <= 1'b0;
			bus_divider_select <= cgu_pkg::CGU_RST_BUS_DIVIDER_SELECT;
			range_select <= 1'b0;
			high_gain_select <= 1'b0;
			low_power_select <= 1'b0;
			external_reference_select <= 1'b0;
			external_reference_enable <= 1'b0;
			external_reference_stop_enable <= 1'b0;
		end else begin
			source_select <= next_source_select;
			reference_divider_select <= next_reference_divider_select;
			internal_reference_select <= next_internal_reference_select;
			internal_reference_enable <= next_internal_reference_enable;
			internal_reference_stop_enable <= next_internal_reference_stop_enable;
			bus_divider_select <= next_bus_divider_select;
			range_select <= next_range_select;
			high_gain_select <= next_high_gain_select;
			low_power_select <= next_low_power_select;
			external_reference_select <= next_external_reference_select;
			external_reference_enable <= next_external_reference_enable;
			external_reference_stop_enable <= next_external_reference_stop_enable;
		end
	end

	// ------------------------------------------------------------
	// Adjust values, held across all but power-on reset
	// ------------------------------------------------------------
	always_comb begin
		next_coarse_adjust = coarse_adjust;
		next_fine_adjust = fine_adjust;
		if (wr_en && paddr == cgu_pkg::CGU_OFF_COARSE) begin
			next_coarse_adjust = wbyte;
		end
		if (wr_en && paddr == cgu_pkg::CGU_OFF_STATUS) begin
			next_fine_adjust = wbyte[cgu_pkg::CGU_POS_FINE];
		end
	end

	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			coarse_adjust <= cgu_pkg::CGU_RST_COARSE;
			fine_adjust <= cgu_pkg::CGU_RST_FINE;
		end else begin
			coarse_adjust <= next_coarse_adjust;
			fine_adjust <= next_fine_adjust;
		end
	end

	assign internal_reference_trim = {coarse_adjust, fine_adjust};

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	logic [1:0] eff_source;
	logic low_power_bypass;
	cgu_pkg::cgu_mode_t next_mode;

	// Reserved code behaves as the FLL output
	assign eff_source = (source_select == 2'h3) ? cgu_pkg::CGU_SRC_FLL : source_select;
	// The debugger keeps the FLL alive even in low-power bypass
	assign low_power_bypass = low_power_select & ~debug_active;

	always_comb begin
		next_mode = cgu_pkg::CGU_ENGAGED_INTERNAL_MODE;
		if (stop_request) begin
			next_mode = cgu_pkg::CGU_STOP_MODE;
		end else begin
			case (eff_source)
				cgu_pkg::CGU_SRC_FLL: begin
					if (internal_reference_select) begin
						next_mode = cgu_pkg::CGU_ENGAGED_INTERNAL_MODE;
					end else begin
						next_mode = cgu_pkg::CGU_ENGAGED_EXTERNAL_MODE;
					end
				end
				cgu_pkg::CGU_SRC_IREF: begin
					if (low_power_bypass) begin
						next_mode = cgu_pkg::CGU_BYPASSED_INTERNAL_LOW_POWER_MODE;
					end else begin
						next_mode = cgu_pkg::CGU_BYPASSED_INTERNAL_MODE;
					end
				end
				cgu_pkg::CGU_SRC_EREF: begin
					if (low_power_bypass) begin
						next_mode = cgu_pkg::CGU_BYPASSED_EXTERNAL_LOW_POWER_MODE;
					end else begin
						next_mode = cgu_pkg::CGU_BYPASSED_EXTERNAL_MODE;
					end
				end
				default: begin
					next_mode = cgu_pkg::CGU_ENGAGED_INTERNAL_MODE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= cgu_pkg::CGU_ENGAGED_INTERNAL_MODE;
		end else begin
			mode <= next_mode;
		end
	end

	logic in_stop;
	logic uses_internal;
	logic uses_external;

	assign in_stop = (mode == cgu_pkg::CGU_STOP_MODE);
	assign fll_enable = ~in_stop & (mode != cgu_pkg::CGU_BYPASSED_INTERNAL_LOW_POWER_MODE) &
		(mode != cgu_pkg::CGU_BYPASSED_EXTERNAL_LOW_POWER_MODE);
	assign uses_internal = (mode == cgu_pkg::CGU_ENGAGED_INTERNAL_MODE) |
		(mode == cgu_pkg::CGU_BYPASSED_INTERNAL_MODE) |
		(mode == cgu_pkg::CGU_BYPASSED_INTERNAL_LOW_POWER_MODE);
	assign uses_external = (mode == cgu_pkg::CGU_ENGAGED_EXTERNAL_MODE) |
		(mode == cgu_pkg::CGU_BYPASSED_EXTERNAL_MODE) |
		(mode == cgu_pkg::CGU_BYPASSED_EXTERNAL_LOW_POWER_MODE);

	// In stop each reference survives only through its own stop enable
	assign internal_reference_active = in_stop ? internal_reference_stop_enable :
		(internal_reference_enable | uses_internal);
	always_comb begin
		osc_ctrl.high_gain_select = high_gain_select;
		osc_ctrl.range_select = range_select;
		osc_ctrl.external_reference_select = external_reference_select;
		osc_ctrl.external_reference_enable = in_stop ?
			(external_reference_enable & external_reference_stop_enable) :
			(external_reference_enable | uses_external);
		osc_ctrl.external_reference_stop_enable = external_reference_stop_enable;
	end

	// ------------------------------------------------------------
	// Reference divider ahead of the FLL
	// ------------------------------------------------------------
	logic [6:0] ref_count, next_ref_count;
	logic [6:0] ref_mask;
	logic fll_ref_in;
	logic next_fll_reference_tick;

	assign fll_ref_in = internal_reference_select ? internal_reference_tick :
		external_reference_tick;
	assign ref_mask = 7'((8'h01 << reference_divider_select) - 8'h01);

	always_comb begin
		next_ref_count = ref_count;
		next_fll_reference_tick = 1'b0;
		if (fll_enable && fll_ref_in) begin
			next_ref_count = 7'(ref_count + 7'h01);
			if ((ref_count & ref_mask) == ref_mask) begin
				next_ref_count = 7'h00;
				next_fll_reference_tick = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_count <= 7'h00;
			fll_reference_tick <= 1'b0;
		end else begin
			ref_count <= next_ref_count;
			fll_reference_tick <= next_fll_reference_tick;
		end
	end

	// ------------------------------------------------------------
	// Source switch, bus divider and clock outputs
	// ------------------------------------------------------------
	logic req_tick;
	logic src_tick;
	logic [2:0] bus_count, next_bus_count;
	logic [2:0] bus_mask;
	logic next_unit_clock_tick;
	logic next_bus_clock;
	logic next_debug_clock;

	function automatic logic tick_of(input logic [1:0] sel, input logic fll_t,
		input logic int_t, input logic ext_t);
		case (sel)
			cgu_pkg::CGU_SRC_IREF: tick_of = int_t;
			cgu_pkg::CGU_SRC_EREF: tick_of = ext_t;
			default: tick_of = fll_t;
		endcase
	endfunction

	// Switching only on an edge of the new source avoids a runt period
	assign req_tick = tick_of(eff_source, dco_tick & fll_enable, internal_reference_tick,
		external_reference_tick);
	assign src_tick = ~in_stop & tick_of(clock_mode_status, dco_tick & fll_enable,
		internal_reference_tick, external_reference_tick);
	assign bus_mask = 3'((4'h1 << bus_divider_select) - 4'h1);

	always_comb begin
		next_clock_mode_status = clock_mode_status;
		next_internal_reference_status = internal_reference_status;
		next_oscillator_ready = oscillator_ready_in & external_reference_select &
			osc_ctrl.external_reference_enable;
		if (req_tick && !in_stop) begin
			next_clock_mode_status = eff_source;
		end
		if (fll_ref_in) begin
			next_internal_reference_status = internal_reference_select;
		end
		next_bus_count = bus_count;
		next_unit_clock_tick = 1'b0;
		next_bus_clock = bus_clock;
		if (src_tick) begin
			next_bus_count = 3'(bus_count + 3'h1);
			if ((bus_count & bus_mask) == bus_mask) begin
				next_bus_count = 3'h0;
				next_unit_clock_tick = 1'b1;
				next_bus_clock = ~bus_clock;
			end
		end
		next_debug_clock = debug_clock;
		if (fll_enable) begin
			if (dco_tick) begin
				next_debug_clock = ~debug_clock;
			end
		end else begin
			next_debug_clock = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_mode_status <= cgu_pkg::CGU_SRC_FLL;
			internal_reference_status <= cgu_pkg::CGU_RST_IREF_SEL;
			oscillator_ready <= 1'b0;
			bus_count <= 3'h0;
			unit_clock_tick <= 1'b0;
			bus_clock <= 1'b0;
			debug_clock <= 1'b0;
		end else begin
			clock_mode_status <= next_clock_mode_status;
			internal_reference_status <= next_internal_reference_status;
			oscillator_ready <= next_oscillator_ready;
			bus_count <= next_bus_count;
			unit_clock_tick <= next_unit_clock_tick;
			bus_clock <= next_bus_clock;
			debug_clock <= next_debug_clock;
		end
	end

	// ------------------------------------------------------------
	// Read data, captured in the setup phase
	// ------------------------------------------------------------
	always_comb begin
		next_prdata = prdata;
		if (rd_setup) begin
			case (paddr)
				cgu_pkg::CGU_OFF_CTRL_ONE: begin
					next_prdata = {24'h000000, source_select, reference_divider_select,
						internal_reference_select, internal_reference_enable,
						internal_reference_stop_enable};
				end
				cgu_pkg::CGU_OFF_CTRL_TWO: begin
					next_prdata = {24'h000000, bus_divider_select, range_select,
						high_gain_select, low_power_select, external_reference_select,
						external_reference_enable, external_reference_stop_enable};
				end
				cgu_pkg::CGU_OFF_COARSE: begin
					next_prdata = {24'h000000, coarse_adjust};
				end
				cgu_pkg::CGU_OFF_STATUS: begin
					next_prdata = {27'h0000000, internal_reference_status,
						clock_mode_status, oscillator_ready, fine_adjust};
				end
				default: begin
					next_prdata = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else begin
			prdata <= next_prdata;
		end
	end

endmodule

/* File: bench/cgu_assertions.sv */
`timescale 1ns/100ps
module cgu_checker (
	// Clock, resets and bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pslverr,
	// Clocking
	input wire logic dco_tick,
	input wire logic internal_reference_tick,
	input wire logic external_reference_tick,
	input wire logic debug_active,
	input wire logic fll_enable,
	input wire logic fll_reference_tick,
	input wire logic [8:0] internal_reference_trim,
	input wire logic unit_clock_tick,
	input wire logic bus_clock,
	input wire logic debug_clock,
	input cgu_pkg::cgu_mode_t mode
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ----
	// Two sampled cycles already spent in stop
	// ----
	sequence in_stop;
		mode == 3'h5 [*2];
	endsequence
	chk_mode_reset: assert property ($rose(presetn) |-> mode == 3'h0)
		else $error("mode not engaged internal after reset");
	chk_trim_por: assert property ($rose(por_n) |-> internal_reference_trim == 9'h100)
		else $error("trim not loaded by power-on reset");
	chk_bus_half: assert property ((bus_clock != $past(bus_clock)) == unit_clock_tick)
		else $error("bus clock toggle without unit tick");
	chk_debug_half: assert property ($past(presetn) && $past(dco_tick && fll_enable) |->
		debug_clock != $past(debug_clock))
		else $error("debug clock missed a dco tick");
	chk_stop_quiet: assert property (in_stop |-> !fll_enable && !debug_clock && !unit_clock_tick)
		else $error("clock activity in stop");
	chk_lp_fll_off: assert property ((mode == 3'h6 || mode == 3'h7) && !debug_active |->
		!fll_enable)
		else $error("fll on in low power bypass");
	chk_fll_kept: assert property (mode inside {3'h0, 3'h1, 3'h2, 3'h3} |-> fll_enable)
		else $error("fll off in engaged or bypass mode");
	chk_unit_cause: assert property (unit_clock_tick |->
		$past(dco_tick || internal_reference_tick || external_reference_tick))
		else $error("unit tick without source tick");
	chk_ref_cause: assert property (fll_reference_tick |->
		$past(internal_reference_tick || external_reference_tick))
		else $error("reference tick without reference");
	chk_unmapped_err: assert property (psel && penable |->
		pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}))
		else $error("slave error flag wrong");
endmodule
bind cgu_top cgu_checker cgu_checker_inst (.pclk, .presetn, .por_n, .psel, .penable, .paddr,
	.pslverr, .dco_tick, .internal_reference_tick, .external_reference_tick, .debug_active,
	.fll_enable, .fll_reference_tick, .internal_reference_trim, .unit_clock_tick, .bus_clock,
	.debug_clock, .mode);

/* File: bench/cgu_osc_model.sv */
`timescale 1ns/100ps
module cgu_osc_model #(
	parameter int DCO_P = 3,
	parameter int IREF_P = 5,
	parameter int EREF_P = 7,
	parameter int OSC_START = 10
) (
	// Controls from the unit
	input wire logic pclk,
	input wire logic fll_enable,
	input wire logic stop_request,
	input wire logic internal_reference_active,
	input cgu_pkg::cgu_osc_ctrl_t osc_ctrl,
	// Clock ticks and oscillator status
	output logic dco_tick,
	output logic internal_reference_tick,
	output logic external_reference_tick,
	output logic oscillator_ready_in
);
	int cd = 0;
	int ci = 0;
	int ce = 0;
	int cs = 0;
	initial begin
		dco_tick = 1'b0;
		internal_reference_tick = 1'b0;
		external_reference_tick = 1'b0;
		oscillator_ready_in = 1'b0;
	end
	// A stopped source gives no ticks; the crystal needs a start-up time
	always @(posedge pclk) begin
		cd <= (cd + 1) % DCO_P;
		ci <= (ci + 1) % IREF_P;
		ce <= (ce + 1) % EREF_P;
		dco_tick <= fll_enable && cd == 0;
		internal_reference_tick <= (!stop_request || internal_reference_active) && ci == 0;
		external_reference_tick <= osc_ctrl.external_reference_enable && ce == 0;
		cs <= osc_ctrl.external_reference_enable ? ((cs < OSC_START) ? cs + 1 : cs) : 0;
		oscillator_ready_in <= cs == OSC_START;
	end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/100ps
module tb;
	// ----
	// Stimulus and probes
	// ----
	localparam int DP = 3;
	localparam int IP = 5;
	localparam int EP = 7;
	localparam logic [11:0] A1 = cgu_pkg::CGU_OFF_CTRL_ONE;
	localparam logic [11:0] A2 = cgu_pkg::CGU_OFF_CTRL_TWO;
	localparam logic [11:0] AC = cgu_pkg::CGU_OFF_COARSE;
	localparam logic [11:0] AS = cgu_pkg::CGU_OFF_STATUS;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic por_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic stop_request = 1'b0;
	logic debug_active = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, dco_tick, internal_reference_tick, external_reference_tick;
	logic oscillator_ready_in, fll_enable, fll_reference_tick, internal_reference_active;
	logic unit_clock_tick, bus_clock, debug_clock;
	logic [8:0] internal_reference_trim;
	cgu_pkg::cgu_osc_ctrl_t osc_ctrl;
	cgu_pkg::cgu_mode_t mode;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [7:0] t1 [6] = '{8'h04, 8'h00, 8'h80, 8'h80, 8'h44, 8'h44};
	logic [7:0] t2 [6] = '{8'h02, 8'h06, 8'h06, 8'h0E, 8'h02, 8'h0A};
	logic [2:0] tm [6] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h2, 3'h6};

	cgu_top cgu_top_inst (.pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .dco_tick, .internal_reference_tick,
		.external_reference_tick, .stop_request, .debug_active, .oscillator_ready_in, .osc_ctrl,
		.fll_enable, .fll_reference_tick, .internal_reference_trim, .internal_reference_active,
		.unit_clock_tick, .bus_clock, .debug_clock, .mode);
	cgu_osc_model #(.DCO_P(DP), .IREF_P(IP), .EREF_P(EP)) cgu_osc_model_inst (.pclk,
		.fll_enable, .stop_request, .internal_reference_active, .osc_ctrl, .dco_tick,
		.internal_reference_tick, .external_reference_tick, .oscillator_ready_in);

	task give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task cmp(input string w, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", w, e, g);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
		@(negedge pclk);
	endtask
	task rchk(input logic [11:0] a, input logic [7:0] e, input string w);
		apb(1'b0, a, 8'h00);
		cmp(w, {24'h000000, e}, rd);
	endtask
	task rst(input logic por);
		@(posedge pclk);
		presetn <= 1'b0;
		por_n <= ~por;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		@(negedge pclk);
	endtask
	function logic pick(input int w);
		case (w)
			0: return unit_clock_tick;
			1: return fll_reference_tick;
			3: return bus_clock;
			default: return debug_clock;
		endcase
	endfunction
	// Second full interval only: the first may be cut by a switch
	task gap(input int w, input int e, input string s);
		int k, c, n;
		logic p;
		k = 0;
		c = 0;
		n = 0;
		p = 1'b1;
		while (k < 3) begin
			@(posedge pclk);
			c++;
			if (pick(w) === 1'b1 && p !== 1'b1) begin
				k++;
				n = c;
				c = 0;
			end
			p = pick(w);
		end
		cmp(s, e, n);
	endtask

	always #25 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			give_verdict();
		end
	end

	initial begin
		rst(1'b1);
		rchk(A1, 8'h04, "ctrl one");
		rchk(A2, 8'h40, "ctrl two");
		rchk(AC, 8'h80, "coarse");
		cmp("mode", 3'h0, mode);
		apb(1'b0, AS, 8'h00);
		cmp("status", 32'h00000010, rd);
		gap(0, 2 * DP, "unit tick gap");
		gap(3, 4 * DP, "bus clock gap");
		apb(1'b0, 12'h010, 8'h00);
		cmp("slverr", 32'h00000001, er);
		cmp("unmapped read", 32'h00000000, rd);
		wr(AC, 8'h5A);
		wr(AS, 8'h01);
		cmp("trim", 9'h0B5, internal_reference_trim);
		rst(1'b0);
		cmp("trim kept", 9'h0B5, internal_reference_trim);
		rst(1'b1);
		cmp("trim por", 9'h100, internal_reference_trim);
		$display("test reset done");
		for (int b = 0; b < 4; b++) begin
			wr(A2, {b[1:0], 6'h00});
			gap(0, DP << b, "unit tick gap");
		end
		wr(A2, 8'h06);
		for (int s = 0; s < 4; s++) begin
			wr(A1, {s[1:0], 6'h04});
			gap(0, (s == 1) ? IP : ((s == 2) ? EP : DP), "source gap");
			apb(1'b0, AS, 8'h00);
			cmp("mode status", (s == 3) ? 0 : s, rd[3:2]);
		end
		cmp("osc ready", 32'h00000001, rd[1]);
		wr(A2, 8'h00);
		for (int r = 0; r < 8; r++) begin
			wr(A1, {2'b00, r[2:0], 3'b100});
			gap(1, IP << r, "reference gap");
		end
		wr(A2, 8'h37);
		cmp("osc ctrl", 5'h1F, osc_ctrl);
		wr(A2, 8'h20);
		cmp("osc ctrl", 5'h08, osc_ctrl);
		$display("test dividers done");
		for (int i = 0; i < 6; i++) begin
			wr(A1, t1[i]);
			wr(A2, t2[i]);
			repeat (30) @(negedge pclk);
			cmp("mode", tm[i], mode);
			cmp("fll enable", !t2[i][3], fll_enable);
			if (!t2[i][3])
				gap(2, 2 * DP, "debug gap");
			else
				cmp("debug clock", 32'h00000000, debug_clock);
		end
		// An active debugger keeps the FLL running in low-power bypass
		@(posedge pclk);
		debug_active <= 1'b1;
		repeat (5) @(negedge pclk);
		cmp("mode", 3'h2, mode);
		cmp("fll enable", 32'h00000001, fll_enable);
		@(posedge pclk);
		debug_active <= 1'b0;
		$display("test modes done");
		for (int j = 0; j < 2; j++) begin
			wr(A1, j ? 8'h04 : 8'h05);
			wr(A2, j ? 8'h03 : 8'h02);
			@(posedge pclk);
			stop_request <= 1'b1;
			repeat (5) @(negedge pclk);
			cmp("mode", 3'h5, mode);
			cmp("fll enable", 32'h00000000, fll_enable);
			cmp("iref active", !j, internal_reference_active);
			cmp("eref enable", j, osc_ctrl.external_reference_enable);
			@(posedge pclk);
			stop_request <= 1'b0;
			repeat (10) @(negedge pclk);
		end
		$display("test stop done");
		give_verdict();
	end
endmodule
